// [inc/acsd_params.svh]
`ifndef ACSD_PARAMS_SVH
`define ACSD_PARAMS_SVH

// ==========================================
// Command byte fields
`define ACSD_SEL_CONV   7
`define ACSD_SEL_SETUP  6
`define ACSD_CHAN_HI    5
`define ACSD_CHAN_LO    3
`define ACSD_SCAN_HI    2
`define ACSD_SCAN_LO    1
`define ACSD_TEMP_BIT   0
`define ACSD_CLK_HI     5
`define ACSD_CLK_LO     4
`define ACSD_VREF_HI    3
`define ACSD_VREF_LO    2
`define ACSD_PAIR_HI    1
`define ACSD_PAIR_LO    0

// ==========================================
// Reset values of the setup fields
`define ACSD_CLK_RST    2'h2
`define ACSD_VREF_RST   2'h2
`define ACSD_PAIR_RST   2'h0

// ==========================================
// Timing counts in conversion clock ticks
`define ACSD_WAKE_CYC   8'hda
`define ACSD_TEMP_CYC   8'hf4

// ==========================================
// Channel numbers and serial framing
`define ACSD_TOP_CHAN   3'h7
`define ACSD_CNV_CHAN   3'h7
`define ACSD_NEGATIVE_VREF_PIN_CHAN  3'h6
`define ACSD_LAST_BIT   3'h7

`endif

// [inc/acsd_pkg.sv]
package acsd_pkg;

	// ==========================================
	// Scan kinds as coded in the conversion byte
	typedef enum logic [1:0] {
		SCAN_UPTO   = 2'h0,
		SCAN_FROM   = 2'h1,
		SCAN_REPEAT = 2'h2,
		SCAN_ONCE   = 2'h3
	} acsd_scan_t;

	// ==========================================
	// Clock modes as coded in the setup byte
	typedef enum logic [1:0] {
		CLK_INT_CNV = 2'h0,
		CLK_INT_ACQ = 2'h1,
		CLK_INT_AIN = 2'h2,
		CLK_EXT     = 2'h3
	} acsd_clk_t;

	// ==========================================
	// Scan sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAKE,
		ST_TEMP,
		ST_PICK,
		ST_CONV
	} acsd_state_t;

endpackage

// [inc/acsd_byte_if.sv]
`timescale 1ns/1ps
interface acsd_byte_if;
	logic [7:0] rxByte;
	logic       rxValid;
	logic       sclkRise;

	modport tx (output rxByte, output rxValid, output sclkRise);
	modport rx (input rxByte, input rxValid, input sclkRise);
endinterface

// [verilog/acsd_shift.sv]
`timescale 1ns/1ps
`include "acsd_params.svh"
module acsd_shift (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Serial pins
	input  wire logic sclk,
	input  wire logic csN,
	input  wire logic din,
	// Byte stream
	acsd_byte_if.tx   rx
);
	logic       sclkPrev;
	logic [2:0] bitCnt;
	logic [6:0] shiftReg;
	wire  logic sclkEdge = ~sclkPrev & sclk;

	always_ff @(posedge clock) begin
		if (rst) begin
			sclkPrev <= 1'b0;
		end else begin
			sclkPrev <= sclk;
		end
	end

	// ==========================================
	// Shift in MSB first, one byte per eight edges
	always_ff @(posedge clock) begin
		if (rst || csN) begin
			bitCnt   <= 3'h0;
			shiftReg <= 7'h00;
		end else if (sclkEdge) begin
			shiftReg <= {shiftReg[5:0], din};
			bitCnt   <= bitCnt + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rx.rxValid  <= 1'b0;
			rx.rxByte   <= 8'h00;
			rx.sclkRise <= 1'b0;
		end else begin
			rx.rxValid  <= sclkEdge & ~csN & (bitCnt == `ACSD_LAST_BIT);
			rx.rxByte   <= {shiftReg, din};
			rx.sclkRise <= sclkEdge;
		end
	end

	chk_byte_eight: assert property (@(posedge clock) disable iff (rst)
		rx.rxValid |-> $past(bitCnt) == `ACSD_LAST_BIT && $past(sclkEdge))
		else $error("byte released before eighth edge");

endmodule // acsd_shift

// [verilog/acsd_decode.sv]
`timescale 1ns/1ps
`include "acsd_params.svh"
module acsd_decode #(
	parameter int unsigned CONV_TICKS = 16,
	parameter int unsigned INT_DIV    = 2
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Serial pins and convert start
	input  wire logic       sclk,
	input  wire logic       csN,
	input  wire logic       din,
	input  wire logic       cnvN,
	// Settings held by neighbouring registers
	input  wire logic [3:0] pairDiff,
	input  wire logic [4:0] repeatNum,
	// Scan activity
	output logic            busy,
	output logic            refOn,
	output logic            chanStart,
	output logic [2:0]      chanNum,
	output logic            chanDiff,
	output logic            tempStart,
	output logic            scanDone,
	// Setup state
	output logic [1:0]      clkMode,
	output logic [1:0]      vrefMode,
	output logic            cnvstIsPin,
	output logic            ref2IsNeg,
	// Pair configuration byte
	output logic            pairWrite,
	output logic            pairBipolar,
	output logic [7:0]      pairData
);
	localparam logic [7:0] CONV_LAST = 8'(CONV_TICKS - 1);
	localparam logic [7:0] DIV_LAST  = 8'(INT_DIV - 1);
	acsd_byte_if bus ();
	acsd_shift u_shift (
		.clock (clock),
		.rst   (rst),
		.sclk  (sclk),
		.csN   (csN),
		.din   (din),
		.rx    (bus.tx)
	);

	// ==========================================
	// Helpers
	function automatic logic chanSkip(input logic [2:0] ch, input logic cnvPin,
		input logic refNeg, input logic [3:0] diff);
		logic pd;
		pd = diff[ch[2:1]];
		chanSkip = (pd && ch[0]) || (ch == `ACSD_CNV_CHAN && cnvPin)
			|| (ch == `ACSD_NEGATIVE_VREF_PIN_CHAN && refNeg)
			|| (pd && ch[2:1] == 2'h3 && (cnvPin || refNeg));
	endfunction

	function automatic logic [2:0] effChan(input logic [2:0] ch, input logic [3:0] diff);
		effChan = diff[ch[2:1]] ? {ch[2:1], 1'b0} : ch;
	endfunction

	// ==========================================
	// Command decode
	logic                    pairPend;
	logic [1:0]              pairSel;
	logic [2:0]              selChan;
	acsd_pkg::acsd_scan_t    scanKind;
	logic                    tempReq;
	logic                    haveCmd;
	logic                    pendStart;
	acsd_pkg::acsd_state_t   state;
	wire logic cmdByte = bus.rxValid & ~pairPend;
	wire logic convWr  = cmdByte & bus.rxByte[`ACSD_SEL_CONV];
	wire logic setupWr = cmdByte & ~bus.rxByte[`ACSD_SEL_CONV]
		& bus.rxByte[`ACSD_SEL_SETUP];

	always_ff @(posedge clock) begin
		if (rst) begin
			selChan  <= 3'h0;
			scanKind <= acsd_pkg::SCAN_ONCE;
			tempReq  <= 1'b0;
			haveCmd  <= 1'b0;
		end else if (convWr) begin
			selChan  <= bus.rxByte[`ACSD_CHAN_HI:`ACSD_CHAN_LO];
			scanKind <= acsd_pkg::acsd_scan_t'(bus.rxByte[`ACSD_SCAN_HI:`ACSD_SCAN_LO]);
			tempReq  <= bus.rxByte[`ACSD_TEMP_BIT];
			haveCmd  <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			clkMode    <= `ACSD_CLK_RST;
			vrefMode   <= `ACSD_VREF_RST;
			pairSel    <= `ACSD_PAIR_RST;
			cnvstIsPin <= 1'b0;
			ref2IsNeg  <= 1'b0;
		end else if (setupWr) begin
			clkMode    <= bus.rxByte[`ACSD_CLK_HI:`ACSD_CLK_LO];
			vrefMode   <= bus.rxByte[`ACSD_VREF_HI:`ACSD_VREF_LO];
			pairSel    <= bus.rxByte[`ACSD_PAIR_HI:`ACSD_PAIR_LO];
			cnvstIsPin <= ~bus.rxByte[`ACSD_CLK_HI];
			ref2IsNeg  <= bus.rxByte[`ACSD_VREF_LO];
		end
	end

	// ==========================================
	// Byte after a setup write with bit 1 set, in the same frame, goes to a pair register
	always_ff @(posedge clock) begin
		if (rst) begin
			pairPend    <= 1'b0;
			pairWrite   <= 1'b0;
			pairBipolar <= 1'b0;
			pairData    <= 8'h00;
		end else begin
			pairWrite <= 1'b0;
			if (setupWr) begin
				pairPend <= bus.rxByte[`ACSD_PAIR_HI];
			end else if (pairPend && bus.rxValid) begin
				pairPend    <= 1'b0;
				pairWrite   <= 1'b1;
				pairBipolar <= pairSel[0];
				pairData    <= bus.rxByte;
			end else if (csN) begin
				pairPend <= 1'b0;
			end
		end
	end

	// ==========================================
	// Conversion clock ticks
	logic [7:0] divCnt;
	logic       intTick;
	logic       cnvPrev;
	always_ff @(posedge clock) begin
		if (rst) begin
			divCnt  <= 8'h00;
			intTick <= 1'b0;
		end else begin
			intTick <= (divCnt == DIV_LAST);
			divCnt  <= (divCnt == DIV_LAST) ? 8'h00 : divCnt + 8'h01;
		end
	end

	// Reset to the idle high level so no false edge follows reset
	always_ff @(posedge clock) begin
		cnvPrev <= rst | cnvN;
	end

	wire logic convTick = (clkMode == acsd_pkg::CLK_EXT) ? bus.sclkRise : intTick;
	wire logic cnvFall  = cnvPrev & ~cnvN;
	wire logic cnvRise  = ~cnvPrev & cnvN;
	wire logic pinStart = haveCmd & ((clkMode == acsd_pkg::CLK_INT_CNV && cnvFall)
		|| (clkMode == acsd_pkg::CLK_INT_ACQ && cnvRise));
	wire logic wrStart  = pendStart & clkMode[1];
	wire logic goScan   = (state == acsd_pkg::ST_IDLE) && (pinStart || wrStart);

	always_ff @(posedge clock) begin
		if (rst) begin
			pendStart <= 1'b0;
		end else if (convWr) begin
			pendStart <= 1'b1;
		end else if (goScan) begin
			pendStart <= 1'b0;
		end
	end

	// ==========================================
	// Scan sequencer
	acsd_pkg::acsd_scan_t sKind;
	logic [2:0]           sTop;
	logic                 sTemp;
	logic [2:0]           cur;
	logic [4:0]           repLeft;
	logic [7:0]           waitCnt;
	logic [7:0]           convCnt;
	logic                 isLast;
	always_comb begin
		unique case (sKind)
			acsd_pkg::SCAN_UPTO:   isLast = (cur == sTop);
			acsd_pkg::SCAN_FROM:   isLast = (cur == `ACSD_TOP_CHAN);
			acsd_pkg::SCAN_REPEAT: isLast = (repLeft <= 5'h1);
			acsd_pkg::SCAN_ONCE:   isLast = 1'b1;
		endcase
	end

	wire logic pickSkip = chanSkip(cur, cnvstIsPin, ref2IsNeg, pairDiff);
	wire logic convEnd  = (state == acsd_pkg::ST_CONV) && convTick && (convCnt == CONV_LAST);
	wire logic advance  = ((state == acsd_pkg::ST_PICK) && pickSkip) || convEnd;
	always_ff @(posedge clock) begin
		if (rst) begin
			state     <= acsd_pkg::ST_IDLE;
			busy      <= 1'b0;
			refOn     <= 1'b0;
			sKind     <= acsd_pkg::SCAN_ONCE;
			sTop      <= 3'h0;
			sTemp     <= 1'b0;
			cur       <= 3'h0;
			repLeft   <= 5'h0;
			waitCnt   <= 8'h00;
			convCnt   <= 8'h00;
			chanStart <= 1'b0;
			chanNum   <= 3'h0;
			chanDiff  <= 1'b0;
			tempStart <= 1'b0;
			scanDone  <= 1'b0;
		end else begin
			chanStart <= 1'b0;
			tempStart <= 1'b0;
			scanDone  <= 1'b0;
			unique case (state)
				acsd_pkg::ST_IDLE: begin
					if (goScan) begin
						state   <= acsd_pkg::ST_WAKE;
						busy    <= 1'b1;
						sKind   <= scanKind;
						sTop    <= effChan(selChan, pairDiff);
						sTemp   <= tempReq;
						repLeft <= repeatNum;
						cur     <= (scanKind == acsd_pkg::SCAN_UPTO) ? 3'h0
							: effChan(selChan, pairDiff);
						refOn   <= refOn | tempReq | ~vrefMode[0];
						if (tempReq) begin
							waitCnt <= `ACSD_TEMP_CYC;
						end else if (!vrefMode[0] && !refOn) begin
							waitCnt <= `ACSD_WAKE_CYC;
						end else begin
							waitCnt <= 8'h00;
						end
					end
				end
				acsd_pkg::ST_WAKE: begin
					if (waitCnt == 8'h00) begin
						convCnt <= 8'h00;
						if (sTemp) begin
							state     <= acsd_pkg::ST_TEMP;
							tempStart <= 1'b1;
						end else begin
							state <= acsd_pkg::ST_PICK;
						end
					end else if (convTick) begin
						waitCnt <= waitCnt - 8'h01;
					end
				end
				acsd_pkg::ST_TEMP: begin
					if (convTick) begin
						if (convCnt == CONV_LAST) begin
							state <= acsd_pkg::ST_PICK;
						end else begin
							convCnt <= convCnt + 8'h01;
						end
					end
				end
				acsd_pkg::ST_PICK: begin
					if (!pickSkip) begin
						state     <= acsd_pkg::ST_CONV;
						convCnt   <= 8'h00;
						chanStart <= 1'b1;
						chanNum   <= cur;
						chanDiff  <= pairDiff[cur[2:1]];
					end
				end
				acsd_pkg::ST_CONV: begin
					if (convTick && !convEnd) begin
						convCnt <= convCnt + 8'h01;
					end
				end
			endcase
			if (advance) begin
				if (isLast) begin
					state    <= acsd_pkg::ST_IDLE;
					busy     <= 1'b0;
					scanDone <= 1'b1;
					refOn    <= 1'b0;
				end else begin
					state   <= acsd_pkg::ST_PICK;
					repLeft <= repLeft - 5'h1;
					if (sKind != acsd_pkg::SCAN_REPEAT) begin
						cur <= cur + 3'h1;
					end
				end
			end
		end
	end

	// ==========================================
	// Checks
	logic [7:0] wakeTicks;
	logic       tempSeen;
	always_ff @(posedge clock) begin
		if (rst || goScan) begin
			wakeTicks <= 8'h00;
			tempSeen  <= 1'b0;
		end else begin
			if (state == acsd_pkg::ST_WAKE && waitCnt != 8'h00 && convTick) begin
				wakeTicks <= wakeTicks + 8'h01;
			end
			if (tempStart) begin
				tempSeen <= 1'b1;
			end
		end
	end

	chk_conv_decode: assert property (@(posedge clock) disable iff (rst)
		convWr |=> selChan == $past(bus.rxByte[5:3]) && tempReq == $past(bus.rxByte[0]))
		else $error("conversion byte not decoded");
	chk_setup_decode: assert property (@(posedge clock) disable iff (rst)
		setupWr |=> clkMode == $past(bus.rxByte[5:4]) && vrefMode == $past(bus.rxByte[3:2]))
		else $error("setup byte not decoded");
	chk_setup_reset: assert property (@(posedge clock)
		rst |=> clkMode == 2'h2 && vrefMode == 2'h2) else $error("setup reset value wrong");
	chk_pin_role: assert property (@(posedge clock) disable iff (rst)
		cnvstIsPin == ~clkMode[1] && ref2IsNeg == vrefMode[0])
		else $error("shared pin roles disagree with setup");
	chk_skip_chan: assert property (@(posedge clock) disable iff (rst)
		chanStart |-> !(chanNum == 3'h7 && cnvstIsPin) && !(chanNum == 3'h6 && ref2IsNeg))
		else $error("reserved channel converted");
	chk_diff_even: assert property (@(posedge clock) disable iff (rst)
		chanStart && chanDiff |-> !chanNum[0])
		else $error("differential pair started on odd channel");
	chk_temp_first: assert property (@(posedge clock) disable iff (rst)
		chanStart && sTemp |-> tempSeen) else $error("channel converted before temperature");
	chk_temp_wake: assert property (@(posedge clock) disable iff (rst)
		tempStart |-> wakeTicks == 8'hf4)
		else $error("temperature wake delay not 244 ticks");
	chk_ref_off: assert property (@(posedge clock) disable iff (rst)
		scanDone |-> !refOn && !busy) else $error("reference left on after scan");
	chk_upto_range: assert property (@(posedge clock) disable iff (rst)
		chanStart && sKind == acsd_pkg::SCAN_UPTO |-> chanNum <= sTop)
		else $error("scan passed the picked channel");
	chk_once_single: assert property (@(posedge clock) disable iff (rst)
		chanStart && sKind == acsd_pkg::SCAN_ONCE |-> ##1 !chanStart [*3])
		else $error("single conversion repeated");
	chk_start_cause: assert property (@(posedge clock) disable iff (rst)
		$rose(busy) |-> $past(clkMode[1] ? pendStart : cnvN != cnvPrev))
		else $error("scan started without its trigger");
	cov_temp_scan: cover property (@(posedge clock) disable iff (rst)
		tempStart ##[1:1000] chanStart);
	cov_repeat_done: cover property (@(posedge clock) disable iff (rst)
		scanDone && sKind == acsd_pkg::SCAN_REPEAT);
	cov_pair_write: cover property (@(posedge clock) disable iff (rst) pairWrite);
	cov_pin_start: cover property (@(posedge clock) disable iff (rst) goScan && pinStart);

endmodule // acsd_decode

// [dv/acsd_host.sv]
`timescale 1ns/1ps
module acsd_host (
	// Clock
	input  wire logic clock,
	// Serial and convert-start pins
	output logic      sclk,
	output logic      csN,
	output logic      din,
	output logic      cnvN
);
	initial begin
		sclk = 1'b0;
		csN  = 1'b1;
		din  = 1'b0;
		cnvN = 1'b1;
	end

	// ==========================================
	// One serial clock level, held two cycles
	task automatic level(input logic lvl);
		sclk = lvl;
		repeat (2) @(negedge clock);
	endtask

	// ==========================================
	// Frame of n bytes, MSB first
	task automatic frame(input logic [15:0] data, input int n);
		@(negedge clock);
		csN = 1'b0;
		for (int i = 8 * n - 1; i >= 0; i--) begin
			din = data[i];
			level(1'b0);
			level(1'b1);
		end
		level(1'b0);
		csN = 1'b1;
		din = ~din;
	endtask

	// ==========================================
	// Free serial clock for mode 11, 2.5 MHz
	task automatic ticks(input int n);
		for (int i = 0; i < n; i++) begin
			din = ~din;
			level(1'b1);
			level(1'b0);
		end
	endtask

	// ==========================================
	// Convert-start low pulse; width times acquisition
	task automatic pulse();
		@(negedge clock);
		cnvN = 1'b0;
		repeat (5) @(negedge clock);
		cnvN = 1'b1;
	endtask
endmodule // acsd_host

// [dv/adc_command_setup_decode_test.sv]
`timescale 1ns/1ps
module adc_command_setup_decode_test;
	// ==========================================
	// Design hookup
	logic        clock, rst, sclk, csN, din, cnvN;
	logic [3:0]  pairDiff;
	logic [4:0]  repeatNum;
	logic        busy, refOn, chanStart, chanDiff, tempStart, scanDone;
	logic [2:0]  chanNum;
	logic [1:0]  clkMode, vrefMode;
	logic        cnvstIsPin, ref2IsNeg, pairWrite, pairBipolar;
	logic [7:0]  pairData;
	int          failures = 0;
	int          comparisons = 0;

	acsd_decode #(.CONV_TICKS(2), .INT_DIV(1)) acsd_decode_inst (
		.clock(clock), .rst(rst), .sclk(sclk), .csN(csN), .din(din), .cnvN(cnvN),
		.pairDiff(pairDiff), .repeatNum(repeatNum), .busy(busy), .refOn(refOn),
		.chanStart(chanStart), .chanNum(chanNum), .chanDiff(chanDiff),
		.tempStart(tempStart), .scanDone(scanDone), .clkMode(clkMode),
		.vrefMode(vrefMode), .cnvstIsPin(cnvstIsPin), .ref2IsNeg(ref2IsNeg),
		.pairWrite(pairWrite), .pairBipolar(pairBipolar), .pairData(pairData));

	acsd_host acsd_host_inst (.clock(clock), .sclk(sclk), .csN(csN), .din(din),
		.cnvN(cnvN));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ==========================================
	// Scan recorder: one nibble per start, temperature as f
	logic [31:0] seenW = 0;
	int          seenN = 0;
	int          age = 0;
	int          firstAt = -1;
	logic        refSeen = 1'b0;
	logic [8:0]  pairSeen = 9'h0;

	always @(posedge clock) begin
		if ((chanStart | tempStart) === 1'b1) begin
			seenW = {seenW[27:0], (tempStart === 1'b1) ? 4'hf : {chanDiff, chanNum}};
			seenN++;
			if (firstAt < 0) begin
				firstAt = age;
				refSeen = refOn;
			end
		end
		if (pairWrite === 1'b1) pairSeen = {pairBipolar, pairData};
		age = (busy === 1'b1) ? age + 1 : 0;
	end

	// ==========================================
	// Compare and sequence tasks
	task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic check_rng(input string nm, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			failures++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	task automatic setup(input logic [7:0] b, input logic [5:0] exp);
		acsd_host_inst.frame({8'h00, b}, 1);
		repeat (3) @(negedge clock);
		check_val("setup", {26'h0, exp}, {26'h0, clkMode, vrefMode, cnvstIsPin, ref2IsNeg});
	endtask

	task automatic arm();
		seenW = 0;
		seenN = 0;
		firstAt = -1;
	endtask

	task automatic scan_end(input string nm, input logic [31:0] expW, input int n);
		int k;
		for (k = 0; k < 3000 && scanDone !== 1'b1; k++) @(negedge clock);
		repeat (2) @(negedge clock);
		check_val({nm, " done"}, 1, k < 3000);
		check_val({nm, " order"}, expW, seenW);
		check_val({nm, " count"}, n, seenN);
		check_val({nm, " ref off"}, 0, refOn);
		check_val({nm, " idle"}, 0, busy);
		$display("test %s done", nm);
	endtask

	task automatic pin_scan(input string nm, input logic midBusy, input logic [31:0] expW,
		input int n);
		arm();
		fork
			acsd_host_inst.pulse();
			begin
				repeat (4) @(negedge clock);
				check_val({nm, " mid pulse"}, midBusy, busy);
				scan_end(nm, expW, n);
			end
		join
	endtask

	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================
	// Conversion byte table, run in mode 10 with vref 01
	logic [7:0]  cb[5] = '{8'h90, 8'haa, 8'ha4, 8'hc7, 8'h9e};
	logic [3:0]  pd[5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
	logic [15:0] ew[5] = '{16'h012, 16'h057, 16'h444, 16'h0f0, 16'h00a};
	int          en[5] = '{3, 2, 3, 2, 1};
	int          lo[5] = '{0, 0, 0, 244, 0};

	initial begin
		rst = 1'b1;
		pairDiff = 4'h0;
		repeatNum = 5'h3;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check_val("reset setup", 32'h28, {26'h0, clkMode, vrefMode, cnvstIsPin, ref2IsNeg});
		check_val("reset pair", 0, pairData);
		arm();
		acsd_host_inst.frame(16'h00de, 1);
		scan_end("wake", 32'h3, 1);
		check_rng("wake span", 218, 224, firstAt);
		check_val("wake ref", 1, refSeen);
		setup(8'h64, 6'h25);
		for (int i = 0; i < 5; i++) begin
			pairDiff = pd[i];
			arm();
			acsd_host_inst.frame({8'h00, cb[i]}, 1);
			scan_end("kind", {16'h0, ew[i]}, en[i]);
			check_rng("wake span", lo[i], lo[i] + 6, firstAt);
			check_val("ref use", i == 3, refSeen);
		end
		acsd_host_inst.frame(16'h6625, 2);
		check_val("pair uni", 32'h025, pairSeen);
		acsd_host_inst.frame(16'h6713, 2);
		check_val("pair bi", 32'h113, pairSeen);
		$display("test pair done");
		setup(8'h74, 6'h35);
		pairDiff = 4'h0;
		arm();
		acsd_host_inst.frame(16'h009e, 1);
		fork
			acsd_host_inst.ticks(60);
			scan_end("ext clock", 32'h3, 1);
		join
		setup(8'h4c, 6'h0f);
		acsd_host_inst.frame(16'h00aa, 1);
		repeat (20) @(negedge clock);
		check_val("no write start", 0, busy);
		pin_scan("pin fall", 1'b1, 32'h5, 1);
		setup(8'h50, 6'h12);
		pin_scan("pin rise", 1'b0, 32'h56, 2);
		check_rng("pin wake", 218, 224, firstAt);
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		$display("[FAIL] watchdog expected finish seen timeout");
		close_out();
	end
endmodule // adc_command_setup_decode_test
